// File: common/shutter_pkg.sv
// Shared types and constants for the shutter / blind command sequencer
package shutter_pkg;

  localparam int unsigned LONG_TICKS_DEFAULT = 50_000_000;
  localparam int unsigned CNT_W_DEFAULT      = 32;

  localparam logic DIR_UP_VAL   = 1'b0;
  localparam logic DIR_DOWN_VAL = 1'b1;
  localparam logic DIR_RESET    = DIR_UP_VAL;

  typedef enum logic [1:0] {
    OBJ_MOVE = 2'h0,
    OBJ_STEP = 2'h1,
    OBJ_STOP = 2'h2
  } obj_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_SHORT = 3'h2,
    ST_LONG  = 3'h4
  } press_state_type;

  typedef struct packed {
    logic    valid;
    obj_type obj;
    logic    dir;
  } cmd_type;

  typedef struct packed {
    logic blind_mode;
    logic toggle_en;
    logic fixed_dir;
  } cfg_type;

endpackage

// File: rtl/press_timer.sv
// Press edge detector and long-press threshold timer
`timescale 1ns/10ps
module press_timer
  import shutter_pkg::*;
#(
  parameter int unsigned CNT_W = CNT_W_DEFAULT
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic             btn_in,
  input  wire logic [CNT_W-1:0] thresh_in,
  output logic                  press_out,
  output logic                  release_out,
  output logic                  long_out
);

  logic             btn_q;
  logic [CNT_W-1:0] cnt_q;
  logic             reached_q;

  initial begin
    if (CNT_W < 2 || CNT_W > 32) $error("press_timer: bad CNT_W");
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) btn_q <= 1'b0;
    else btn_q <= btn_in;
  end

  // Held duration counted in clock ticks; saturates after threshold
  always_ff @(posedge clk_in) begin
    if (!nrst_in || !btn_q) begin
      cnt_q     <= '0;
      reached_q <= 1'b0;
    end else if (!reached_q) begin
      if (cnt_q + 1'b1 >= thresh_in) reached_q <= 1'b1;
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign press_out   = btn_in & ~btn_q;
  assign release_out = ~btn_in & btn_q;
  // One-cycle pulse as the held press crosses the threshold
  assign long_out    = btn_q & btn_in & ~reached_q
                       & (cnt_q + 1'b1 >= thresh_in);

endmodule

// File: rtl/dir_select.sv
// Movement direction: toggling or fixed per input
`timescale 1ns/10ps
module dir_select
  import shutter_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic press_in,
  input  wire cfg_type cfg_in,
  output logic      dir_out
);

  logic last_q;

  // Last direction sent on a new activation
  always_ff @(posedge clk_in) begin
    if (!nrst_in) last_q <= ~DIR_RESET;
    else if (press_in) last_q <= dir_out;
  end

  // Toggle inverts each new activation, else fixed direction
  always_comb begin
    if (cfg_in.toggle_en) dir_out = ~last_q;
    else dir_out = cfg_in.fixed_dir;
  end

endmodule

// File: rtl/shutter_blind_command_sequencer.sv
// Shutter / venetian blind command sequencer for one pushbutton input
`timescale 1ns/10ps
module shutter_blind_command_sequencer
  import shutter_pkg::*;
#(
  parameter int unsigned CNT_W = CNT_W_DEFAULT
) (
  input  wire logic             CLK_IN,
  input  wire logic             NRST_IN,
  input  wire logic             BUTTON_IN,
  input  wire logic             BLIND_MODE_IN,
  input  wire logic             TOGGLE_EN_IN,
  input  wire logic             FIXED_DIR_IN,
  input  wire logic [CNT_W-1:0] LONG_TICKS_IN,
  output logic                  CMD_VALID_OUT,
  output logic [1:0]            CMD_OBJ_OUT,
  output logic                  CMD_DIR_OUT
);

  cfg_type         cfg;
  cfg_type         cfg_q;
  press_state_type state_q;
  cmd_type         cmd_d;
  cmd_type         cmd_q;
  logic            press;
  logic            rel;
  logic            long_hit;
  logic            dir_now;
  logic            dir_q;

  initial begin
    if (CNT_W < 2 || CNT_W > 32) $error("sequencer: bad CNT_W");
  end

  assign cfg = '{blind_mode: BLIND_MODE_IN,
                 toggle_en:  TOGGLE_EN_IN,
                 fixed_dir:  FIXED_DIR_IN};

  press_timer #(.CNT_W(CNT_W)) u_timer (
    .clk_in      (CLK_IN),
    .nrst_in     (NRST_IN),
    .btn_in      (BUTTON_IN),
    .thresh_in   (LONG_TICKS_IN),
    .press_out   (press),
    .release_out (rel),
    .long_out    (long_hit)
  );

  dir_select u_dir (
    .clk_in   (CLK_IN),
    .nrst_in  (NRST_IN),
    .press_in (press),
    .cfg_in   (cfg),
    .dir_out  (dir_now)
  );

  // Mode and direction latched at press so a mid-press change is harmless
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      cfg_q <= '0;
      dir_q <= DIR_RESET;
    end else if (press) begin
      cfg_q <= cfg;
      dir_q <= dir_now;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) state_q <= ST_IDLE;
    else begin
      unique case (state_q)
        ST_IDLE:  if (press) state_q <= ST_SHORT;
        ST_SHORT: begin
          if (rel) state_q <= ST_IDLE;
          else if (long_hit) state_q <= ST_LONG;
        end
        ST_LONG:  if (rel) state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // One command at most per event; release wins over threshold
  always_comb begin
    cmd_d = '{valid: 1'b0, obj: OBJ_MOVE, dir: dir_q};
    unique case (state_q)
      ST_IDLE: begin
        if (press && !cfg.blind_mode) begin
          cmd_d = '{valid: 1'b1, obj: OBJ_MOVE, dir: dir_now};
        end
      end
      ST_SHORT: begin
        if (rel) begin
          if (cfg_q.blind_mode) begin
            cmd_d = '{valid: 1'b1, obj: OBJ_STEP, dir: dir_q};
          end
          // Shutter short release sends nothing
        end else if (long_hit && cfg_q.blind_mode) begin
          cmd_d = '{valid: 1'b1, obj: OBJ_MOVE, dir: dir_q};
        end
      end
      ST_LONG: begin
        if (rel && !cfg_q.blind_mode) begin
          cmd_d = '{valid: 1'b1, obj: OBJ_STOP, dir: dir_q};
        end
        // Blind long release is silent; halt only by short press
      end
      default: cmd_d = '{valid: 1'b0, obj: OBJ_MOVE, dir: dir_q};
    endcase
  end

  // Shutter uses move/stop, blind uses move/stop-step
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) cmd_q <= '{valid: 1'b0, obj: OBJ_MOVE, dir: DIR_RESET};
    else cmd_q <= cmd_d;
  end

  assign CMD_VALID_OUT = cmd_q.valid;
  assign CMD_OBJ_OUT   = cmd_q.obj;
  assign CMD_DIR_OUT   = cmd_q.dir;

endmodule

// File: verif/seq_checker_asserts.sv
// Port-level checks for the command sequencer
`timescale 1ns/10ps
module seq_checker
  import shutter_pkg::*;
#(
  parameter int unsigned CNT_W = CNT_W_DEFAULT
) (
  input wire logic             CLK_IN,
  input wire logic             NRST_IN,
  input wire logic             BUTTON_IN,
  input wire logic             BLIND_MODE_IN,
  input wire logic             TOGGLE_EN_IN,
  input wire logic             FIXED_DIR_IN,
  input wire logic [CNT_W-1:0] LONG_TICKS_IN,
  input wire logic             CMD_VALID_OUT,
  input wire logic [1:0]       CMD_OBJ_OUT,
  input wire logic             CMD_DIR_OUT
);
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  a_press_move: assert property (
    !BLIND_MODE_IN && $rose(BUTTON_IN) |=> CMD_VALID_OUT &&
    CMD_OBJ_OUT == 2'h0) else $error("no move at press");
  a_blind_quiet: assert property (
    BLIND_MODE_IN && $rose(BUTTON_IN) |=> !CMD_VALID_OUT)
    else $error("blind press sent");
  a_one_pulse: assert property (
    CMD_VALID_OUT |=> !CMD_VALID_OUT) else $error("pulse too long");
  a_release_obj: assert property (
    $fell(BUTTON_IN) |=> !CMD_VALID_OUT ||
    CMD_OBJ_OUT == (BLIND_MODE_IN ? 2'h1 : 2'h2)) else $error("bad obj");
  a_blind_step: assert property (
    BLIND_MODE_IN && $rose(BUTTON_IN) ##1 BUTTON_IN ##1 $fell(BUTTON_IN)
    |=> CMD_VALID_OUT && CMD_OBJ_OUT == 2'h1) else $error("no step");
  a_short_quiet: assert property (
    !BLIND_MODE_IN && $rose(BUTTON_IN) ##1 BUTTON_IN ##1 $fell(BUTTON_IN)
    |=> !CMD_VALID_OUT) else $error("short release sent");
  a_long_release: assert property (
    (LONG_TICKS_IN <= 4 && BUTTON_IN) [*8] ##1 $fell(BUTTON_IN) |=>
    CMD_VALID_OUT == !BLIND_MODE_IN &&
    (BLIND_MODE_IN || CMD_OBJ_OUT == 2'h2)) else $error("long release");
  a_fixed_dir: assert property (
    CMD_VALID_OUT && !TOGGLE_EN_IN && CMD_OBJ_OUT != 2'h2 |->
    CMD_DIR_OUT == FIXED_DIR_IN) else $error("wrong fixed dir");
endmodule
bind shutter_blind_command_sequencer seq_checker #(.CNT_W(CNT_W)) CHK (
  .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .BUTTON_IN(BUTTON_IN),
  .BLIND_MODE_IN(BLIND_MODE_IN), .TOGGLE_EN_IN(TOGGLE_EN_IN),
  .FIXED_DIR_IN(FIXED_DIR_IN), .LONG_TICKS_IN(LONG_TICKS_IN),
  .CMD_VALID_OUT(CMD_VALID_OUT), .CMD_OBJ_OUT(CMD_OBJ_OUT),
  .CMD_DIR_OUT(CMD_DIR_OUT));

// File: verif/actuator_model.sv
// Behavioural shutter / blind actuator
`timescale 1ns/10ps
module actuator_model
  import shutter_pkg::*;
(
  input  wire logic    clk_in,
  input  wire logic    nrst_in,
  input  wire cmd_type cmd_in,
  output logic         moving_out,
  output logic [7:0]   steps_out
);
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      moving_out <= 1'b0;
      steps_out  <= 8'h00;
    end else if (cmd_in.valid) begin
      case (cmd_in.obj)
        OBJ_MOVE: moving_out <= 1'b1;
        OBJ_STEP: begin
          if (!moving_out)
            steps_out <= steps_out + 8'h01;
          moving_out <= 1'b0;
        end
        default: moving_out <= 1'b0;
      endcase
    end
  end
endmodule

// File: verif/shutter_blind_command_sequencer_bench.sv
// Self-checking bench for the command sequencer
`timescale 1ns/10ps
module shutter_blind_command_sequencer_bench;
  import shutter_pkg::*;
  logic       clk = 0;
  logic       nrst = 0;
  logic       btn = 0;
  cfg_type    cfg = '0;
  logic       vld;
  logic [1:0] obj;
  logic       dir;
  logic       mov;
  logic [7:0] stp;
  logic [2:0] got[$];
  int         n_errors = 0;
  int         tests_run = 0;
  always #5 clk = ~clk;
  shutter_blind_command_sequencer #(.CNT_W(8)) DUT (.CLK_IN(clk),
    .NRST_IN(nrst), .BUTTON_IN(btn), .BLIND_MODE_IN(cfg.blind_mode),
    .TOGGLE_EN_IN(cfg.toggle_en), .FIXED_DIR_IN(cfg.fixed_dir),
    .LONG_TICKS_IN(8'h04), .CMD_VALID_OUT(vld), .CMD_OBJ_OUT(obj),
    .CMD_DIR_OUT(dir));
  actuator_model ACT (.clk_in(clk), .nrst_in(nrst),
    .cmd_in({vld, obj_type'(obj), dir}), .moving_out(mov),
    .steps_out(stp));
  // Log of commands; old values read at the edge, so no race
  always @(posedge clk) if (vld === 1'b1) got.push_back({obj, dir});
  task automatic fail(string m);
    n_errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic hit(cfg_type c, int hold);
    @(negedge clk);
    cfg = c;
    got = {};
    btn = 1;
    repeat (hold) @(negedge clk);
    btn = 0;
    repeat (10) @(negedge clk);
  endtask
  // Stop direction is left open, so only its object is compared
  task automatic chk(int n, logic [2:0] a, logic [1:0] b);
    tests_run++;
    if (got.size() != n || got[0] !== a || (n > 1 && got[1][2:1] !== b))
      fail("command sequence");
  endtask
  task automatic t_shutter;
    hit(3'b001, 2);
    chk(1, 3'b001, 2'h0);
    if (mov !== 1'b1) fail("not moving");
    hit(3'b000, 9);
    chk(2, 3'b000, 2'h2);
    if (mov !== 1'b0) fail("still moving");
  endtask
  task automatic t_blind;
    hit(3'b101, 2);
    chk(1, 3'b011, 2'h0);
    if (stp !== 8'h01) fail("no step");
    hit(3'b100, 9);
    chk(1, 3'b000, 2'h0);
    hit(3'b101, 2);
    chk(1, 3'b011, 2'h0);
    if (mov !== 1'b0 || stp !== 8'h01) fail("not halted");
  endtask
  task automatic t_toggle;
    logic d;
    hit(3'b010, 2);
    chk(1, 3'b000, 2'h0);
    d = got[0][0];
    hit(3'b010, 2);
    chk(1, {2'h0, !d}, 2'h0);
    hit(3'b010, 2);
    chk(1, {2'h0, d}, 2'h0);
  endtask
  task automatic results;
    $display("errors %0d tests %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1;
    t_shutter();
    t_blind();
    t_toggle();
    results();
  end
  initial begin
    #20000;
    n_errors++;
    results();
  end
endmodule
